/* hdl/pgen_defines.svh */
// Purpose: offsets, reset values, field positions and timing figures
// Assumes: byte-wide registers at indirect offsets 0x00..0x1f
// Notes:   definitions only
`ifndef PGEN_DEFINES_SVH
`define PGEN_DEFINES_SVH

`define PGEN_OFS_CTL        5'h01
`define PGEN_OFS_CFG        5'h02
`define PGEN_OFS_PID        5'h03
`define PGEN_OFS_LINE_HI    5'h04
`define PGEN_OFS_LINE_LO    5'h05
`define PGEN_OFS_BAR_HI     5'h06
`define PGEN_OFS_BAR_LO     5'h07
`define PGEN_OFS_ACT_HI     5'h08
`define PGEN_OFS_ACT_LO     5'h09
`define PGEN_OFS_TOT_HI     5'h0a
`define PGEN_OFS_TOT_LO     5'h0b
`define PGEN_OFS_PD_HI      5'h0c
`define PGEN_OFS_PD_LO      5'h0d
`define PGEN_OFS_VBP        5'h0e
`define PGEN_OFS_VFP        5'h0f
`define PGEN_OFS_COLOUR     5'h10
`define PGEN_OFS_STATUS     5'h1f

`define PGEN_RST_CTL        8'h00
`define PGEN_RST_CFG        8'h33
`define PGEN_RST_PID        8'h24
`define PGEN_RST_LINE_HI    8'h07
`define PGEN_RST_LINE_LO    8'h80
`define PGEN_RST_BAR_HI     8'h00
`define PGEN_RST_BAR_LO     8'hf0
`define PGEN_RST_ACT_HI     8'h01
`define PGEN_RST_ACT_LO     8'he0
`define PGEN_RST_TOT_HI     8'h02
`define PGEN_RST_TOT_LO     8'h0d
`define PGEN_RST_PD_HI      8'h0c
`define PGEN_RST_PD_LO      8'h67
`define PGEN_RST_VBP        8'h21
`define PGEN_RST_VFP        8'h0a
`define PGEN_RST_COLOUR0    8'haa
`define PGEN_RST_COLOUR1    8'h33
`define PGEN_RST_COLOUR2    8'hf0
`define PGEN_RST_COLOUR3    8'h7f
`define PGEN_RST_COLOUR_HI  8'h00

// writable-bit masks
`define PGEN_MASK_CTL       8'h01
`define PGEN_MASK_CFG       8'hbf

`define PGEN_BIT_ENABLE     0
`define PGEN_BIT_FIXED      7
`define PGEN_BARS_MSB       5
`define PGEN_BARS_LSB       4
`define PGEN_BLK_MSB        3
`define PGEN_BLK_LSB        0
`define PGEN_VC_MSB         7
`define PGEN_VC_LSB         6
`define PGEN_DT_MSB         5
`define PGEN_DT_LSB         0

// line-period units and clock period, in picoseconds
`define PGEN_CLK_PERIOD_PS  31'h0000c350
`define PGEN_UNIT_10NS_PS   15'h2710
`define PGEN_UNIT_13NS_PS   15'h3415
`define PGEN_UNIT_20NS_PS   15'h4e20

`endif

/* hdl/pgen_pkg.sv */
// Purpose: types shared by the pattern generator files
// Assumes: nothing
// Notes:   numbers live in pgen_defines.svh
package pgen_pkg;

   typedef enum logic [2:0] {
      PGEN_IDLE = 3'b000,
      PGEN_WAIT = 3'b001,
      PGEN_FS   = 3'b011,
      PGEN_LH   = 3'b010,
      PGEN_PL   = 3'b110,
      PGEN_FE   = 3'b111
   } pgen_state_t;

   typedef enum logic [1:0] {
      PGEN_RATE_400  = 2'h0,
      PGEN_RATE_800  = 2'h1,
      PGEN_RATE_1200 = 2'h2,
      PGEN_RATE_1600 = 2'h3
   } pgen_rate_t;

   typedef enum logic [1:0] {
      PGEN_BEAT_FS   = 2'h0,
      PGEN_BEAT_FE   = 2'h1,
      PGEN_BEAT_LHDR = 2'h2,
      PGEN_BEAT_DATA = 2'h3
   } pgen_beat_kind_t;

   typedef struct packed {
      pgen_beat_kind_t kind;
      logic [1:0]      vc;
      logic [5:0]      dt;
      logic [15:0]     word_count;
      logic [7:0]      data;
      logic            last;
   } pgen_beat_t;

   typedef struct packed {
      logic       wr_en;
      logic [4:0] addr;
      logic [7:0] wdata;
   } pgen_reg_req_t;

endpackage : pgen_pkg

/* hdl/pgen_regs.sv */
// Purpose: byte register bank of the pattern generator
// Assumes: one access per cycle, read data one cycle after the address
// Notes:   reserved bits read as zero, status byte is read-only
`include "pgen_defines.svh"
module pgen_regs (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   // access port
   input  wire pgen_pkg::pgen_reg_req_t req_i,
   output logic       [7:0]           rdata_o,
   // block side
   input  wire logic  [7:0]           status_i,
   output logic       [31:0][7:0]     regs_o
);
   import pgen_pkg::*;

   logic [31:0][7:0] regs_reg;

   function automatic logic [7:0] rst_val(input logic [4:0] a);
      case (a)
         `PGEN_OFS_CTL:     rst_val = `PGEN_RST_CTL;
         `PGEN_OFS_CFG:     rst_val = `PGEN_RST_CFG;
         `PGEN_OFS_PID:     rst_val = `PGEN_RST_PID;
         `PGEN_OFS_LINE_HI: rst_val = `PGEN_RST_LINE_HI;
         `PGEN_OFS_LINE_LO: rst_val = `PGEN_RST_LINE_LO;
         `PGEN_OFS_BAR_HI:  rst_val = `PGEN_RST_BAR_HI;
         `PGEN_OFS_BAR_LO:  rst_val = `PGEN_RST_BAR_LO;
         `PGEN_OFS_ACT_HI:  rst_val = `PGEN_RST_ACT_HI;
         `PGEN_OFS_ACT_LO:  rst_val = `PGEN_RST_ACT_LO;
         `PGEN_OFS_TOT_HI:  rst_val = `PGEN_RST_TOT_HI;
         `PGEN_OFS_TOT_LO:  rst_val = `PGEN_RST_TOT_LO;
         `PGEN_OFS_PD_HI:   rst_val = `PGEN_RST_PD_HI;
         `PGEN_OFS_PD_LO:   rst_val = `PGEN_RST_PD_LO;
         `PGEN_OFS_VBP:     rst_val = `PGEN_RST_VBP;
         `PGEN_OFS_VFP:     rst_val = `PGEN_RST_VFP;
         5'h10:             rst_val = `PGEN_RST_COLOUR0;
         5'h11:             rst_val = `PGEN_RST_COLOUR1;
         5'h12:             rst_val = `PGEN_RST_COLOUR2;
         5'h13:             rst_val = `PGEN_RST_COLOUR3;
         default:           rst_val = `PGEN_RST_COLOUR_HI;
      endcase
   endfunction

   function automatic logic [7:0] wr_mask(input logic [4:0] a);
      case (a)
         5'h00:             wr_mask = 8'h00;
         `PGEN_OFS_CTL:     wr_mask = `PGEN_MASK_CTL;
         `PGEN_OFS_CFG:     wr_mask = `PGEN_MASK_CFG;
         `PGEN_OFS_STATUS:  wr_mask = 8'h00;
         default:           wr_mask = 8'hff;
      endcase
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_byte
         localparam logic [4:0] IDX  = 5'(gi);
         localparam logic [7:0] RSTV = rst_val(IDX);
         localparam logic [7:0] MSK  = wr_mask(IDX);
         wire hit = req_i.wr_en && (req_i.addr == IDX);
         always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
               regs_reg[gi] <= RSTV;
            end else if (hit) begin
               regs_reg[gi] <= req_i.wdata & MSK;
            end
         end
      end
   endgenerate

   wire [7:0] rd_sel = (req_i.addr == `PGEN_OFS_STATUS) ? status_i : regs_reg[req_i.addr];

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rd_sel;
      end
   end

   assign regs_o = regs_reg;

endmodule // pgen_regs

/* hdl/pgen_tick.sv */
// Purpose: line-period timer, one pulse per programmed line period
// Assumes: 20 MHz clock
// Notes:   period scaled in picoseconds so 13.33 ns units stay exact enough
`include "pgen_defines.svh"
module pgen_tick (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   // control
   input  wire logic                 run_i,
   input  wire logic [15:0]          period_i,
   input  wire pgen_pkg::pgen_rate_t rate_i,
   // output
   output logic                      tick_o
);
   import pgen_pkg::*;

   logic [30:0] acc_reg;
   logic [14:0] unit_ps;

   always_comb begin
      case (rate_i)
         PGEN_RATE_1200: unit_ps = `PGEN_UNIT_13NS_PS;
         PGEN_RATE_400:  unit_ps = `PGEN_UNIT_20NS_PS;
         default:        unit_ps = `PGEN_UNIT_10NS_PS;
      endcase
   end

   // widened first so the product never wraps
   wire [30:0] target   = {15'h0000, period_i} * {16'h0000, unit_ps};
   wire [30:0] acc_step = acc_reg + `PGEN_CLK_PERIOD_PS;
   // line ends once elapsed time covers the period, never faster than one cycle
   wire        done     = (acc_step >= target);

   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !run_i) begin
         acc_reg <= 31'h0;
         tick_o  <= 1'b0;
      end else begin
         acc_reg <= done ? 31'h0 : acc_step;
         tick_o  <= done;
      end
   end

endmodule // pgen_tick

/* hdl/pgen_top.sv */
// Purpose: CSI-2 test pattern generator, colour bars or fixed colour blocks
// Assumes: byte register port at indirect offsets, downstream ready/valid
// Notes:   one beat per cycle, held while tx_ready_i is low
`include "pgen_defines.svh"
module pgen_top (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_b_i,
   // register port
   input  wire pgen_pkg::pgen_reg_req_t reg_req_i,
   output logic       [7:0]             reg_rdata_o,
   // lane rate of the transmit path
   input  wire pgen_pkg::pgen_rate_t    lane_rate_i,
   // beat stream to the CSI-2 transmit path
   output logic                         tx_valid_o,
   input  wire logic                    tx_ready_i,
   output pgen_pkg::pgen_beat_t         tx_o,
   // state
   output logic                         running_o
);
   import pgen_pkg::*;

   logic [31:0][7:0] regs;
   logic [7:0]       status;
   logic             tick;

   pgen_state_t state_reg;
   pgen_state_t state_next;
   logic [15:0] line_reg;
   logic [15:0] line_next;
   logic        pend_reg;
   logic        pend_next;
   logic [15:0] byte_reg;
   logic [15:0] byte_next;
   logic [2:0]  bar_reg;
   logic [2:0]  bar_next;
   logic [15:0] pos_reg;
   logic [15:0] pos_next;
   logic [3:0]  blk_reg;
   logic [3:0]  blk_next;

   // register fields
   wire        generator_on           = regs[`PGEN_OFS_CTL][`PGEN_BIT_ENABLE];
   wire        fixed_colour_select    = regs[`PGEN_OFS_CFG][`PGEN_BIT_FIXED];
   wire [1:0]  bar_count_code         = regs[`PGEN_OFS_CFG][`PGEN_BARS_MSB:`PGEN_BARS_LSB];
   wire [3:0]  block_bytes            = regs[`PGEN_OFS_CFG][`PGEN_BLK_MSB:`PGEN_BLK_LSB];
   wire [1:0]  packet_virtual_channel = regs[`PGEN_OFS_PID][`PGEN_VC_MSB:`PGEN_VC_LSB];
   wire [5:0]  packet_data_type       = regs[`PGEN_OFS_PID][`PGEN_DT_MSB:`PGEN_DT_LSB];
   wire [15:0] line_payload_bytes     = {regs[`PGEN_OFS_LINE_HI], regs[`PGEN_OFS_LINE_LO]};
   wire [15:0] bar_width_bytes        = {regs[`PGEN_OFS_BAR_HI], regs[`PGEN_OFS_BAR_LO]};
   wire [15:0] active_line_count      = {regs[`PGEN_OFS_ACT_HI], regs[`PGEN_OFS_ACT_LO]};
   wire [15:0] frame_line_count       = {regs[`PGEN_OFS_TOT_HI], regs[`PGEN_OFS_TOT_LO]};
   wire [15:0] line_period_count      = {regs[`PGEN_OFS_PD_HI], regs[`PGEN_OFS_PD_LO]};
   wire [7:0]  vertical_back_blank    = regs[`PGEN_OFS_VBP];
   wire [7:0]  vertical_front_blank   = regs[`PGEN_OFS_VFP];

   pgen_regs u_regs (
      .clk_i    (clk_i),
      .rst_b_i  (rst_b_i),
      .req_i    (reg_req_i),
      .rdata_o  (reg_rdata_o),
      .status_i (status),
      .regs_o   (regs)
   );

   pgen_tick u_tick (
      .clk_i    (clk_i),
      .rst_b_i  (rst_b_i),
      .run_i    (state_reg != PGEN_IDLE),
      .period_i (line_period_count),
      .rate_i   (lane_rate_i),
      .tick_o   (tick)
   );

   // frame layout: start packet on line 0, back porch, active, front porch, end
   wire [16:0] act_first = {9'h0, vertical_back_blank} + 17'h1;
   wire [16:0] act_last  = {9'h0, vertical_back_blank} + {1'b0, active_line_count};
   wire [16:0] fe_line   = act_last + {9'h0, vertical_front_blank} + 17'h1;
   wire [16:0] line_x    = {1'b0, line_reg};
   wire        in_active = (line_x >= act_first) && (line_x <= act_last);
   wire        at_fe     = (line_x == fe_line);
   wire        at_wrap   = (line_x + 17'h1 >= {1'b0, frame_line_count});
   wire        line_go   = pend_reg || tick;

   // payload byte source
   wire [2:0]  bars_m1   = 3'((4'h1 << bar_count_code) - 4'h1);
   wire        last_bar  = (bar_reg == bars_m1);
   wire        bar_end   = !last_bar && (pos_reg + 16'h1 >= bar_width_bytes);
   wire        blk_end   = ({1'b0, blk_reg} + 5'h1 >= {1'b0, block_bytes});
   wire [7:0]  bar_byte  = regs[`PGEN_OFS_COLOUR + {2'b00, bar_reg}];
   wire [7:0]  blk_byte  = regs[`PGEN_OFS_COLOUR + {1'b0, blk_reg}];
   wire        last_byte = (byte_reg + 16'h1 >= line_payload_bytes);
   wire        beat_done = tx_valid_o && tx_ready_i;

   always_comb begin
      state_next = state_reg;
      line_next  = line_reg;
      pend_next  = pend_reg | tick;
      byte_next  = byte_reg;
      bar_next   = bar_reg;
      pos_next   = pos_reg;
      blk_next   = blk_reg;
      case (state_reg)
         PGEN_IDLE: begin
            pend_next = 1'b0;
            if (generator_on) begin
               state_next = PGEN_WAIT;
               line_next  = 16'h0;
               pend_next  = 1'b1;
            end
         end
         PGEN_WAIT: begin
            if (line_go) begin
               // a tick meeting a pending line stays pending
               pend_next = pend_reg & tick;
               line_next = at_wrap ? 16'h0 : line_reg + 16'h1;
               if (line_reg == 16'h0) begin
                  // only a frame boundary may stop the generator
                  state_next = generator_on ? PGEN_FS : PGEN_IDLE;
               end else if (in_active) begin
                  state_next = PGEN_LH;
               end else if (at_fe) begin
                  state_next = PGEN_FE;
               end
            end
         end
         PGEN_FS, PGEN_FE: begin
            if (beat_done) begin
               state_next = PGEN_WAIT;
            end
         end
         PGEN_LH: begin
            if (beat_done) begin
               byte_next  = 16'h0;
               bar_next   = 3'h0;
               pos_next   = 16'h0;
               blk_next   = 4'h0;
               state_next = (line_payload_bytes == 16'h0) ? PGEN_WAIT : PGEN_PL;
            end
         end
         PGEN_PL: begin
            if (beat_done) begin
               byte_next = byte_reg + 16'h1;
               blk_next  = blk_end ? 4'h0 : blk_reg + 4'h1;
               if (bar_end) begin
                  bar_next = bar_reg + 3'h1;
                  pos_next = 16'h0;
               end else begin
                  pos_next = pos_reg + 16'h1;
               end
               if (last_byte) begin
                  state_next = PGEN_WAIT;
               end
            end
         end
         default: begin
            state_next = PGEN_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_reg <= PGEN_IDLE;
         line_reg  <= 16'h0;
         pend_reg  <= 1'b0;
         byte_reg  <= 16'h0;
         bar_reg   <= 3'h0;
         pos_reg   <= 16'h0;
         blk_reg   <= 4'h0;
      end else begin
         state_reg <= state_next;
         line_reg  <= line_next;
         pend_reg  <= pend_next;
         byte_reg  <= byte_next;
         bar_reg   <= bar_next;
         pos_reg   <= pos_next;
         blk_reg   <= blk_next;
      end
   end

   // beat assembly
   always_comb begin
      tx_o            = '0;
      tx_o.vc         = packet_virtual_channel;
      tx_o.dt         = packet_data_type;
      tx_o.word_count = line_payload_bytes;
      case (state_reg)
         PGEN_FS:  tx_o.kind = PGEN_BEAT_FS;
         PGEN_FE:  tx_o.kind = PGEN_BEAT_FE;
         PGEN_LH:  tx_o.kind = PGEN_BEAT_LHDR;
         PGEN_PL: begin
            tx_o.kind = PGEN_BEAT_DATA;
            tx_o.data = fixed_colour_select ? blk_byte : bar_byte;
            tx_o.last = last_byte;
         end
         default:  tx_o.kind = PGEN_BEAT_FS;
      endcase
   end

   assign tx_valid_o = (state_reg == PGEN_FS) || (state_reg == PGEN_FE) ||
                       (state_reg == PGEN_LH) || (state_reg == PGEN_PL);
   assign running_o  = (state_reg != PGEN_IDLE);
   assign status     = {6'h00, in_active && running_o, running_o};

endmodule // pgen_top

/* sim/pgen_tx_sink.sv */
// Purpose: transmit-path sink taking beats at full rate or with stalls
// Assumes: a beat passes on a rising edge with valid and ready high
// Notes:   slow mode is ready on every other cycle only
module pgen_tx_sink (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // handshake
   input  wire logic slow_i,
   output logic      tx_ready_o
);
   logic ph_reg;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) ph_reg <= 1'b0;
      else ph_reg <= !ph_reg;
   end
   assign tx_ready_o = !slow_i || ph_reg;
endmodule // pgen_tx_sink

/* sim/pgen_top_assertions.sv */
// Purpose: port assertions of the pattern generator
// Assumes: one clock, sync active-low reset
// Notes:   bound into pgen_top
module pgen_chk (
   // clock and reset
   input wire logic                    clk_i,
   input wire logic                    rst_b_i,
   // watched ports
   input wire pgen_pkg::pgen_reg_req_t reg_req_i,
   input wire logic                    tx_valid_o,
   input wire logic                    tx_ready_i,
   input wire pgen_pkg::pgen_beat_t    tx_o,
   input wire logic                    running_o
);
   import pgen_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire acc = tx_valid_o && tx_ready_i;
   wire on_wr = reg_req_i.wr_en && reg_req_i.addr == 5'h01 && reg_req_i.wdata[0];
   wire is_dat = tx_o.kind == PGEN_BEAT_DATA;
   a_reset_quiet: assert property ($rose(rst_b_i) |-> !tx_valid_o && !running_o)
      else $error("output active after reset");
   a_enable_run: assert property (on_wr && !running_o |-> ##[1:3] running_o)
      else $error("enable did not start");
   a_start_first: assert property ($rose(running_o) |->
      ##[0:3] (tx_valid_o && tx_o.kind == PGEN_BEAT_FS))
      else $error("no frame start");
   a_beat_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o))
      else $error("beat dropped");
   a_idle_quiet: assert property (!running_o |-> !tx_valid_o)
      else $error("beat while idle");
   a_side_zero: assert property (tx_valid_o && !is_dat |-> tx_o.data == 8'h00 && !tx_o.last)
      else $error("bad short packet");
   a_hdr_data: assert property (acc && tx_o.kind == PGEN_BEAT_LHDR && tx_o.word_count != 16'h0
      |=> tx_valid_o && is_dat)
      else $error("no data after header");
   a_data_run: assert property (acc && is_dat && !tx_o.last |=> tx_valid_o && is_dat)
      else $error("payload broken");
   c_frame_end: cover property (acc && tx_o.kind == PGEN_BEAT_FE);
   c_stall: cover property (tx_valid_o && !tx_ready_i);
   c_line_end: cover property (acc && tx_o.last);
endmodule // pgen_chk
bind pgen_top pgen_chk u_chk (.clk_i, .rst_b_i, .reg_req_i, .tx_valid_o, .tx_ready_i,
   .tx_o, .running_o);

/* sim/tb_pgen_top.sv */
// Purpose: self-checking bench of the pattern generator
// Assumes: inputs change 1 ns after the rising edge
// Notes:   short frames keep the run brief
module tb_pgen_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pgen_pkg::*;
   logic          clk_i = 1'b0;
   logic          rst_b_i = 1'b0;
   logic          slow = 1'b0;
   pgen_reg_req_t reg_req_i = '0;
   pgen_rate_t    lane_rate_i = PGEN_RATE_800;
   logic [7:0]    reg_rdata_o;
   logic          tx_valid_o;
   logic          tx_ready_i;
   logic          running_o;
   pgen_beat_t    tx_o;
   int            num_errors = 0;
   int            n_tests = 0;
   int            cyc = 0;
   pgen_beat_t    bq[$];
   int            tq[$];
   logic [7:0]    col[8] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'hc4, 8'hc5, 8'hc6, 8'hc7};
   // rows: {write, addr}, wdata, read value
   logic [23:0]   regs[21] = '{24'h01_00_00, 24'h02_00_33, 24'h03_00_24, 24'h04_00_07,
      24'h05_00_80, 24'h06_00_00, 24'h07_00_f0, 24'h08_00_01, 24'h09_00_e0, 24'h0a_00_02,
      24'h0b_00_0d, 24'h0c_00_0c, 24'h0e_00_21, 24'h10_00_aa, 24'h11_00_33, 24'h12_00_f0,
      24'h13_00_7f, 24'h81_fe_00, 24'h82_ff_bf, 24'h80_55_00, 24'h9f_5a_00};
   // rows: addr, data of the short frame
   logic [15:0]   setup[15] = '{16'h03c5, 16'h0400, 16'h050a, 16'h0800, 16'h0902, 16'h0a00,
      16'h0b08, 16'h0c00, 16'h0d64, 16'h0e01, 16'h0f01, 16'h14c4, 16'h15c5, 16'h16c6, 16'h17c7};
   // rows: rate, slow, cfg, bar width, line period in cycles
   logic [31:0]   modes[6] = '{32'h1000_0214, 32'h3010_0214, 32'h2020_021b, 32'h1031_0114,
      32'h0183_0228, 32'h0182_0228};

   pgen_top uut (.clk_i, .rst_b_i, .reg_req_i, .reg_rdata_o, .lane_rate_i,
      .tx_valid_o, .tx_ready_i, .tx_o, .running_o);
   pgen_tx_sink u_sink (.clk_i, .rst_b_i, .slow_i(slow), .tx_ready_o(tx_ready_i));

   always #25 clk_i = ~clk_i;
   // beats pass at the next rising edge, settled here
   always @(negedge clk_i) begin
      cyc++;
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
         bq.push_back(tx_o);
         tq.push_back(cyc);
      end
      if (cyc == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (num_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // write strobe left high; caller lowers it or writes again
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      reg_req_i = '{1'b1, a, d};
      @(posedge clk_i);
      #1;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      reg_req_i = '{1'b0, a, 8'h00};
      @(posedge clk_i);
      #1 d = reg_rdata_o;
   endtask

   function automatic logic [7:0] expb(int k, logic [7:0] cfg, int bar);
      int n;
      n = k / bar;
      if (n > (1 << cfg[5:4]) - 1) n = (1 << cfg[5:4]) - 1;
      if (cfg[7]) n = k % cfg[3:0];
      return col[n];
   endfunction

   function automatic bit near(int d, int e);
      return d >= e - 4 && d <= e + 4;
   endfunction

   initial begin
      logic [7:0]  rv;
      logic [31:0] m;
      int          p;
      int          t;
      repeat (2) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      foreach (regs[i]) begin
         if (regs[i][23]) wr(regs[i][20:16], regs[i][15:8]);
         rd(regs[i][20:16], rv);
         chk(rv, regs[i][7:0]);
      end
      foreach (setup[i]) wr(setup[i][12:8], setup[i][7:0]);
      foreach (modes[i]) begin
         m = modes[i];
         wr(5'h06, 8'h00);
         wr(5'h07, m[15:8]);
         wr(5'h02, m[23:16]);
         lane_rate_i = pgen_rate_t'(m[29:28]);
         slow = m[24];
         bq.delete();
         tq.delete();
         wr(5'h01, 8'h01);
         reg_req_i.wr_en = 1'b0;
         for (int k = 0; k < 200 && bq.size() == 0; k++) @(negedge clk_i);
         @(posedge clk_i);
         #1 wr(5'h01, 8'h00);
         reg_req_i.wr_en = 1'b0;
         for (int k = 0; k < 2000 && running_o !== 1'b0; k++) @(negedge clk_i);
         t = cyc;
         chk(16'(bq.size()), 16'h0018);
         for (int j = 0; j < 24 && j < bq.size(); j++) begin
            p = (j - 1) % 11;
            chk(bq[j].kind, j == 0 ? 2'h0 : j == 23 ? 2'h1 : p == 0 ? 2'h2 : 2'h3);
            if (bq[j].kind != PGEN_BEAT_DATA) chk({bq[j].vc, bq[j].dt}, 8'hc5);
            else chk({bq[j].last, bq[j].data},
               {p == 10, expb(p - 1, m[23:16], m[15:8])});
            if (p == 0 && j < 23) chk(bq[j].word_count, 16'h000a);
         end
         chk(near(tq[12] - tq[1], m[7:0]), 1'b1);
         chk(near(tq[1] - tq[0], 2 * m[7:0]), 1'b1);
         chk(near(tq[23] - tq[12], 2 * m[7:0]), 1'b1);
         chk(near(t - tq[0], 8 * m[7:0]), 1'b1);
         @(posedge clk_i);
         #1;
      end
      // reset while the first payload byte is still on offer, status shows running first
      wr(5'h01, 8'h01);
      rd(5'h1f, rv);
      rd(5'h1f, rv);
      chk(rv[0], 1'b1);
      repeat (82) @(posedge clk_i);
      #1 rst_b_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 chk({tx_valid_o, running_o}, 2'b00);
      rst_b_i = 1'b1;
      bq.delete();
      rd(5'h01, rv);
      chk(rv, 8'h00);
      rd(5'h03, rv);
      chk(rv, 8'h24);
      repeat (50) @(posedge clk_i);
      chk(16'(bq.size()), 16'd0);
      tally_and_finish();
   end
endmodule // tb_pgen_top
